// ==== design/tip_pkg.sv ====
// Purpose: Constants shared by the tunnel information header parser
// Assumes: Byte-wide tunnel payload stream, header fields sent MSB first
// Notes:   Header is 12 bytes, 16 with the timestamp
package tip_pkg;
  localparam int          HDR_BASE_BYTES  = 12;
  localparam int          HDR_TS_BYTES    = 4;
  // Byte offsets of fields within the header
  localparam logic [3:0]  OFS_ADDR        = 4'h0;
  localparam logic [3:0]  OFS_PORT        = 4'h4;
  localparam logic [3:0]  OFS_LEN         = 4'h6;
  localparam logic [3:0]  OFS_GROUP       = 4'h8;
  localparam logic [3:0]  OFS_CAT         = 4'hA;
  localparam logic [3:0]  OFS_FLAGS       = 4'hB;
  localparam logic [3:0]  OFS_LAST_BASE   = 4'hB;
  localparam logic [3:0]  OFS_LAST_TS     = 4'hF;
  // Bit positions in the flags byte
  localparam int          BIT_RAP         = 7;
  localparam int          BIT_TS          = 6;
  localparam int          BIT_WAKE_HI     = 5;
  localparam int          BIT_WAKE_LO     = 4;
  // Category codes
  localparam logic [7:0]  CAT_WAKE_LO     = 8'h01;
  localparam logic [7:0]  CAT_WAKE_HI     = 8'h05;
  localparam logic [7:0]  CAT_SIG_LO      = 8'h01;
  localparam logic [7:0]  CAT_SIG_HI      = 8'h06;
  localparam logic [7:0]  CAT_SIG_MULTI   = 8'h0E;
  localparam logic [7:0]  CAT_SIG_USER    = 8'h0F;
  localparam logic [7:0]  CAT_AUDIO_LO    = 8'h80;
  localparam logic [7:0]  CAT_AUDIO_HI    = 8'h81;
  localparam logic [7:0]  CAT_DATA_LO     = 8'hC0;
  localparam logic [7:0]  CAT_DATA_HI     = 8'hC3;
  localparam logic [7:0]  CAT_UNSPEC      = 8'hFF;
  // Reset values
  localparam logic [15:0] RST_PIPE        = 16'h0000;

  typedef enum logic [3:0]
  {
    ST_HDR  = 4'b0001,
    ST_TS   = 4'b0010,
    ST_BODY = 4'b0100,
    ST_SKIP = 4'b1000
  } tip_state_type;
endpackage

// ==== design/tip_fifo.sv ====
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Registered outputs; holds data until the drain side takes it
`timescale 1ns/1ps
`default_nettype none
module tip_fifo
  import tip_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // Drain side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("tip_fifo: bad WIDTH or DEPTH");
  end

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             push, pop;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb
  begin
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push)
    begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt        = wrPtr_r + 1'b1;
    end
    if (pop)
      rdPtr_nxt = rdPtr_r + 1'b1;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    mem_r <= mem_nxt;
    if (!rstn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== design/tip_parser.sv ====
// Purpose: Parses tunnel information headers and routes inner packets to pipes
// Assumes: Byte stream of tunnel payloads, header at every packet start
// Notes:   Header bytes are consumed, only inner packet bytes are forwarded
//
// Overview of operation
// (R1) An information header precedes every inner packet starting in the payload.
// (R2) Header: address 32, port 16, length 16, group 16, category 8, flags, reserved.
// (R3) Wakeup bits meaningful for categories 1 to 5, otherwise ignored.
// (R4) Timestamp-present flag adds a 32-bit timestamp after the reserved bits.
// (R5) Length counts all inner packet bytes, even across tunnel payloads.
// (R6) Address, port and group together map each inner packet to a stream; the lookup here matches address and port only, not group.
// (R7) Sender copies inner destination address and port into the header.
// (R8) Sender puts signalling group or service identifier in the group field.
// (R9) Category codes: signalling 1-6,14,15; audio 128,129; data 192-195.
// (R10) Category 255 is unspecified yet still routed by address and port.
// (R11) Sender sets random-access flag on packets carrying random-access data.
// (R12) Inner packet and header are separated from the tunnel before forwarding.
// (R13) The header is dropped and never forwarded.
// (R14) Inner packet bytes pass unaltered; routing uses header fields only.
// (R15) Matching address and port select that entry's configured pipe.
// (R16) No matching entry selects the fallback pipe.
// (R17) Length-field bytes are counted as the packet across payload boundaries.
// (R18) Multi-bit fields arrive most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module tip_parser
  import tip_pkg::*;
#(
  parameter int ENTRIES = 4,
  parameter int DEPTH   = 32
)
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Stream map configuration
  input  wire logic [ENTRIES-1:0]   mapValid,
  input  wire logic [32*ENTRIES-1:0] mapAddr,
  input  wire logic [16*ENTRIES-1:0] mapPort,
  input  wire logic [16*ENTRIES-1:0] mapPipe,
  input  wire logic [15:0]          fallbackPipeId,
  // Tunnel payload input
  input  wire logic [7:0]           tunData,
  input  wire logic                 tunValid,
  input  wire logic                 tunFirst,
  output logic                      tunReady,
  // Routed inner packet output
  output logic [7:0]                pipeData,
  output logic                      pipeValid,
  input  wire logic                 pipeReady,
  output logic [15:0]               pipeId_r,
  output logic                      pipeStart_r,
  output logic [7:0]                category_r,
  output logic                      randAccess_r,
  output logic [1:0]                wakeup_r,
  output logic                      tsPresent_r,
  output logic [31:0]               timestamp_r,
  output logic [15:0]               group_r,
  output logic                      catKnown_r
);
  initial
  begin
    if (ENTRIES < 1 || ENTRIES > 64)
      $error("tip_parser: bad ENTRIES");
  end

  function automatic logic isKnownCat(input logic [7:0] c);
    isKnownCat = (c >= CAT_SIG_LO && c <= CAT_SIG_HI) || c == CAT_SIG_MULTI || c == CAT_SIG_USER
              || (c >= CAT_AUDIO_LO && c <= CAT_AUDIO_HI)
              || (c >= CAT_DATA_LO && c <= CAT_DATA_HI) || c == CAT_UNSPEC;  // see (R9) (R10)
  endfunction

  function automatic logic isWakeCat(input logic [7:0] c);
    isWakeCat = (c >= CAT_WAKE_LO && c <= CAT_WAKE_HI);  // see (R3)
  endfunction

  // ==========================================================
  // Header parse state
  tip_state_type state_r, state_nxt;
  logic [3:0]    idx_r, idx_nxt;
  logic [31:0]   addr_r, addr_nxt;
  logic [15:0]   port_r, port_nxt;
  logic [15:0]   len_r, len_nxt;
  logic [15:0]   grp_nxt, pipe_nxt;
  logic [7:0]    cat_nxt;
  logic          rap_nxt, tsf_nxt, start_nxt, known_nxt;
  logic [1:0]    wake_nxt;
  logic [31:0]   ts_nxt;
  logic          fifoInReady, take, hdrDone;
  logic [3:0]    hdrIdx;
  logic [15:0]   lookupPipe;

  // Stream map lookup, lowest entry wins
  always_comb
  begin
    lookupPipe = fallbackPipeId;  // see (R16)
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (mapValid[i] && mapAddr[32*i +: 32] == addr_r && mapPort[16*i +: 16] == port_r)
        lookupPipe = mapPipe[16*i +: 16];  // see (R6) (R15) (R10)
    end
  end

  // Body bytes wait for FIFO space, header bytes never do
  assign tunReady = (state_r == ST_BODY) ? fifoInReady : 1'b1;
  assign take     = tunValid && tunReady;
  // A payload start inside a header restarts it at byte 0
  assign hdrIdx   = tunFirst ? 4'h0 : idx_r;  // see (R1)
  assign hdrDone  = (state_r == ST_HDR && hdrIdx == OFS_LAST_BASE && !tunData[BIT_TS])
                 || (state_r == ST_TS && hdrIdx == OFS_LAST_TS);

  always_comb
  begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    addr_nxt  = addr_r;
    port_nxt  = port_r;
    len_nxt   = len_r;
    grp_nxt   = group_r;
    cat_nxt   = category_r;
    rap_nxt   = randAccess_r;
    tsf_nxt   = tsPresent_r;
    wake_nxt  = wakeup_r;
    ts_nxt    = timestamp_r;
    pipe_nxt  = pipeId_r;
    known_nxt = catKnown_r;
    start_nxt = pipeStart_r && !(pipeValid && pipeReady);
    if (take)
    begin
      case (state_r)
        ST_HDR, ST_TS:
        begin
          if (tunFirst)
            state_nxt = ST_HDR;  // see (R1)
          idx_nxt = hdrIdx + 4'h1;
          if (hdrIdx < OFS_PORT)
            addr_nxt = {addr_r[23:0], tunData};  // see (R2) (R18)
          else if (hdrIdx < OFS_LEN)
            port_nxt = {port_r[7:0], tunData};
          else if (hdrIdx < OFS_GROUP)
            len_nxt = {len_r[7:0], tunData};
          else if (hdrIdx < OFS_CAT)
            grp_nxt = {group_r[7:0], tunData};
          else if (hdrIdx == OFS_CAT)
          begin
            cat_nxt   = tunData;
            known_nxt = isKnownCat(tunData);  // see (R9) (R10)
            if (!isWakeCat(tunData))
              wake_nxt = 2'b00;  // see (R3)
          end
          else if (hdrIdx == OFS_FLAGS)
          begin
            rap_nxt   = tunData[BIT_RAP];
            tsf_nxt   = tunData[BIT_TS];
            if (isWakeCat(category_r))
              wake_nxt = tunData[BIT_WAKE_HI:BIT_WAKE_LO];  // see (R3)
            else
              wake_nxt = 2'b00;
            if (tunData[BIT_TS])
              state_nxt = ST_TS;  // see (R4)
          end
          else
            ts_nxt = {timestamp_r[23:0], tunData};  // see (R4) (R18)
          if (hdrDone)
          begin
            idx_nxt   = '0;
            pipe_nxt  = lookupPipe;  // see (R6) (R15) (R16)
            start_nxt = 1'b1;
            state_nxt = (len_r == '0) ? ST_HDR : ST_BODY;  // see (R13) (R12)
          end
        end
        ST_BODY:
        begin
          len_nxt = len_r - 1'b1;  // see (R5) (R17)
          if (len_r == 16'h0001)
            state_nxt = ST_HDR;  // see (R1)
        end
        default:
        begin
          state_nxt = ST_HDR;
          idx_nxt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_r      <= ST_HDR;
      idx_r        <= '0;
      addr_r       <= '0;
      port_r       <= '0;
      len_r        <= '0;
      group_r      <= '0;
      category_r   <= '0;
      randAccess_r <= 1'b0;
      tsPresent_r  <= 1'b0;
      wakeup_r     <= 2'b00;
      timestamp_r  <= '0;
      pipeId_r     <= RST_PIPE;
      pipeStart_r  <= 1'b0;
      catKnown_r   <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      idx_r        <= idx_nxt;
      addr_r       <= addr_nxt;
      port_r       <= port_nxt;
      len_r        <= len_nxt;
      group_r      <= grp_nxt;
      category_r   <= cat_nxt;
      randAccess_r <= rap_nxt;
      tsPresent_r  <= tsf_nxt;
      wakeup_r     <= wake_nxt;
      timestamp_r  <= ts_nxt;
      pipeId_r     <= pipe_nxt;
      pipeStart_r  <= start_nxt;
      catKnown_r   <= known_nxt;
    end
  end

  // ==========================================================
  // Inner packet bytes pass through the FIFO unaltered
  tip_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) uFifo (
    .core_clk (core_clk),
    .rstn     (rstn),
    .inData   (tunData),                             // see (R14)
    .inValid  (tunValid && state_r == ST_BODY),      // see (R13)
    .inReady  (fifoInReady),
    .outData  (pipeData),
    .outValid (pipeValid),
    .outReady (pipeReady)
  );
endmodule
`default_nettype wire

// ==== bench/tip_parser_sva.sv ====
// Purpose: Port checks for the header parser
// Assumes: One clock, sync active-low reset
// Notes:   Bound to tip_parser
`timescale 1ns/1ps
`default_nettype none
module tip_parser_sva
(
  // Watched ports
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        tunValid,
  input  wire logic        tunReady,
  input  wire logic [7:0]  pipeData,
  input  wire logic        pipeValid,
  input  wire logic        pipeReady,
  input  wire logic        pipeStart_r,
  input  wire logic [7:0]  category_r,
  input  wire logic [1:0]  wakeup_r,
  input  wire logic        catKnown_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_hold;
    pipeValid && !pipeReady |=> pipeValid && $stable(pipeData);
  endproperty
  a_hold: assert property (p_hold) else $error("output byte changed while stalled");
  property p_wake;
    !(category_r inside {[8'h01:8'h05]}) |-> wakeup_r == 2'b00;
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup bits kept");
  property p_catknown;
    category_r inside {[8'h01:8'h06], 8'h0E, 8'h0F, 8'h80, 8'h81, [8'hC0:8'hC3]} |-> catKnown_r;
  endproperty
  a_catknown: assert property (p_catknown) else $error("listed category not known");
  property p_rise;
    $rose(pipeValid) |-> $past(tunValid && tunReady);
  endproperty
  a_rise: assert property (p_rise) else $error("output without input byte");
  property p_stall;
    !tunReady |-> pipeValid;
  endproperty
  a_stall: assert property (p_stall) else $error("refused with empty buffer");
  property p_stuck;
    !tunReady && !pipeReady |=> !tunReady;
  endproperty
  a_stuck: assert property (p_stuck) else $error("full buffer accepted");
  property p_release;
    $rose(rstn) |-> !pipeValid && tunReady && !pipeStart_r;
  endproperty
  a_release: assert property (p_release) else $error("bad state after reset");
  property p_catstable;
    $changed(category_r) |-> $past(tunValid && tunReady);
  endproperty
  a_catstable: assert property (p_catstable) else $error("category changed idle");
endmodule
bind tip_parser tip_parser_sva i_tip_parser_sva (.core_clk(core_clk), .rstn(rstn), .tunValid(tunValid),
  .tunReady(tunReady), .pipeData(pipeData), .pipeValid(pipeValid), .pipeReady(pipeReady),
  .pipeStart_r(pipeStart_r), .category_r(category_r), .wakeup_r(wakeup_r), .catKnown_r(catKnown_r));
`default_nettype wire

// ==== bench/tip_source_model.sv ====
// Purpose: Tunnel source sending headers and bytes
// Assumes: Bytes held until tunReady at a rising edge
// Notes:   Released data is inverted
`timescale 1ns/1ps
`default_nettype none
module tip_source_model
(
  // Clock
  input  wire logic       core_clk,
  // Tunnel stream
  output logic [7:0]      tunData,
  output logic            tunValid,
  output logic            tunFirst,
  input  wire logic       tunReady
);
  initial
  begin
    tunData  = 8'hA5;
    tunValid = 1'b0;
    tunFirst = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b, input logic first, input logic last);
    @(negedge core_clk);
    tunData  = b;
    tunValid = 1'b1;
    tunFirst = first;
    do @(posedge core_clk); while (tunReady !== 1'b1);
    if (last)
    begin
      @(negedge core_clk);
      tunValid = 1'b0;
      tunFirst = 1'b0;
      tunData  = ~b;
    end
  endtask
  task automatic send_hdr(input logic [31:0] addr, input logic [15:0] port, len, grp,
                          input logic [7:0] cat, flags, input logic [31:0] ts, input logic last);
    logic [127:0] h;
    int           n;
    h = {addr, port, len, grp, cat, flags, ts};
    n = flags[6] ? 16 : 12;
    for (int k = 0; k < n; k++)
      send_byte(h[127-8*k -: 8], k == 0, last && k == n - 1);
  endtask
endmodule
`default_nettype wire

// ==== bench/tip_parser_tb.sv ====
// Purpose: Self-checking bench for tip_parser
// Assumes: Random headers from a fixed seed
// Notes:   Expected bytes queued as sent
`timescale 1ns/1ps
`default_nettype none
module tip_parser_tb;
  import tip_pkg::*;
  logic          core_clk, rstn, tunValid, tunFirst, tunReady, pipeValid, pipeReady, pipeStart_r;
  logic          randAccess_r, tsPresent_r, catKnown_r, stallAll;
  logic [3:0]    mapValid;
  logic [127:0]  mapAddr;
  logic [63:0]   mapPort, mapPipe;
  logic [15:0]   fallbackPipeId, pipeId_r, group_r;
  logic [7:0]    tunData, pipeData, category_r;
  logic [1:0]    wakeup_r;
  logic [31:0]   timestamp_r, seed;
  logic [7:0]    cats [13] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h0E, 8'h0F, 8'h80, 8'h81, 8'hC0, 8'hC3, 8'hFF, 8'h00, 8'h07};
  logic [7:0]    expQ [$];
  int            fail_count, checks, cycles;
  bit            sawFull;
  tip_parser #(.ENTRIES(4), .DEPTH(32)) i_tip_parser (.core_clk(core_clk), .rstn(rstn), .mapValid(mapValid),
    .mapAddr(mapAddr), .mapPort(mapPort), .mapPipe(mapPipe), .fallbackPipeId(fallbackPipeId), .tunData(tunData),
    .tunValid(tunValid), .tunFirst(tunFirst), .tunReady(tunReady), .pipeData(pipeData), .pipeValid(pipeValid),
    .pipeReady(pipeReady), .pipeId_r(pipeId_r), .pipeStart_r(pipeStart_r), .category_r(category_r),
    .randAccess_r(randAccess_r), .wakeup_r(wakeup_r), .tsPresent_r(tsPresent_r), .timestamp_r(timestamp_r),
    .group_r(group_r), .catKnown_r(catKnown_r));
  tip_source_model i_tip_source_model (.core_clk(core_clk), .tunData(tunData), .tunValid(tunValid),
    .tunFirst(tunFirst), .tunReady(tunReady));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [15:0] exp_pipe(input logic [31:0] a, input logic [15:0] p);
    for (int i = 0; i < 4; i++)
      if (mapValid[i] && mapAddr[32*i +: 32] == a && mapPort[16*i +: 16] == p)
        return mapPipe[16*i +: 16];
    return fallbackPipeId;
  endfunction
  function automatic logic exp_known(input logic [7:0] c);
    return (c >= 8'h01 && c <= 8'h06) || c == 8'h0E || c == 8'h0F || c == 8'h80 || c == 8'h81
        || (c >= 8'hC0 && c <= 8'hC3) || c == 8'hFF;
  endfunction
  task automatic pkt(input logic [31:0] addr, input logic [15:0] port, len, input logic [7:0] cat, flags);
    logic [15:0] grp;
    logic [31:0] ts;
    logic [7:0]  b;
    grp = $random(seed);
    ts = $random(seed);
    i_tip_source_model.send_hdr(addr, port, len, grp, cat, flags, ts, len == 16'h0000);
    #1;
    chk(pipeId_r, exp_pipe(addr, port), "pipe");
    chk(category_r, cat, "category");
    chk(catKnown_r, exp_known(cat), "known");
    chk(pipeStart_r, 1, "start");
    chk(group_r, grp, "group");
    chk(randAccess_r, flags[7], "rap");
    chk(tsPresent_r, flags[6], "ts flag");
    if (flags[6]) chk(timestamp_r, ts, "stamp");
    chk(wakeup_r, (cat >= 8'h01 && cat <= 8'h05) ? flags[5:4] : 2'b00, "wake");
    for (int k = 0; k < len; k++)
    begin
      b = $random(seed);
      expQ.push_back(b);
      i_tip_source_model.send_byte(b, k == 3, k == len - 1);
    end
  endtask
  always @(negedge core_clk) pipeReady <= !stallAll && ($random(seed) % 4 != 0);
  always @(posedge core_clk)
  begin
    cycles++;
    if (tunReady === 1'b0) sawFull = 1;
    if (pipeValid === 1'b1 && pipeReady === 1'b1)
    begin
      chk(expQ.size() > 0, 1, "extra byte");
      if (expQ.size() > 0) chk(pipeData, expQ.pop_front(), "data");
    end
    if (cycles > 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  initial
  begin
    seed = 32'h6F27FA36;
    rstn = 1'b0;
    stallAll = 1'b0;
    pipeReady = 1'b1;
    mapValid = 4'b1011;
    mapAddr = {$random(seed), $random(seed), $random(seed), $random(seed)};
    mapPort = {$random(seed), $random(seed)};
    mapPipe = {$random(seed), $random(seed)};
    fallbackPipeId = $random(seed);
    mapAddr[127:96] = mapAddr[31:0];
    mapPort[63:48] = mapPort[15:0];
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    for (int n = 0; n < 40; n++)
      if (n % 5 == 4) pkt($random(seed), $random(seed), n % 7, cats[n % 13], $random(seed) & 8'hF0);
      else pkt(mapAddr[32*(n%5) +: 32], mapPort[16*(n%5) +: 16], n % 7, cats[n % 13], $random(seed) & 8'hF0);
    $display("test random done");
    for (int k = 0; k < 5; k++) i_tip_source_model.send_byte(8'h3C, k == 0, 1'b0);
    pkt(mapAddr[63:32], mapPort[31:16], 16'h0005, 8'h04, 8'hF0);
    $display("test restart done");
    stallAll = 1'b1;
    fork
      pkt(mapAddr[31:0], mapPort[15:0], 16'h0028, 8'hC1, 8'h80);
      begin
        repeat (100) @(negedge core_clk);
        stallAll = 1'b0;
      end
    join
    for (int w = 0; w < 300 && expQ.size() > 0; w++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    chk(sawFull, 1, "never full");
    chk(pipeValid, 0, "drained");
    chk(expQ.size(), 0, "lost bytes");
    $display("test fill done");
    end_of_test();
  end
endmodule
`default_nettype wire
